// ==== verilog/ucb_pkg.sv ====
// Constants shared by the UTOPIA cell buffer configuration block
package ucb_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] UCB_OFS_MAIN   = 8'h00;
  localparam logic [7:0] UCB_OFS_MODE   = 8'h04;
  localparam logic [7:0] UCB_OFS_STATUS = 8'h08;
  localparam logic [7:0] UCB_OFS_QMAP   = 8'h0C;
  localparam logic [7:0] UCB_OFS_PORT   = 8'h10;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UCB_BIT_FFS      = 4;
  localparam int UCB_BIT_GUARD    = 6;
  localparam int UCB_DIVQ_LO      = 8;
  localparam int UCB_BIT_ATM      = 0;
  localparam int UCB_BIT_LVL2     = 1;
  localparam int UCB_PORTS_LO     = 8;
  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [15:0] UCB_MAIN_RST  = 16'h0000;
  localparam logic [15:0] UCB_MODE_RST  = 16'h0101;
  localparam logic [15:0] UCB_MAIN_MASK = 16'h0750;
  localparam logic [15:0] UCB_MODE_MASK = 16'h3F03;
  // ****************************************************************
  // Buffer figures
  // ****************************************************************
  localparam logic [3:0] UCB_FULL_CELLS  = 4'h4;
  localparam logic [7:0] UCB_TX_CELLS    = 8'h80;
  localparam logic [5:0] UCB_PORTS_FULL  = 6'h20;
  localparam logic [5:0] UCB_PORTS_LIGHT = 6'h10;
  localparam logic [2:0] UCB_QPP_WIDE    = 3'h4;
  localparam logic [2:0] UCB_QPP_NARROW  = 3'h2;
  localparam logic [6:0] UCB_Q_LIGHT_64  = 7'h20;
  // Partition codes
  typedef enum logic [2:0] {
    UCB_DIV_4   = 3'h0,
    UCB_DIV_8   = 3'h1,
    UCB_DIV_16  = 3'h2,
    UCB_DIV_32  = 3'h3,
    UCB_DIV_64  = 3'h4,
    UCB_DIV_1   = 3'h5,
    UCB_DIV_R6  = 3'h6,
    UCB_DIV_R7  = 3'h7
  } ucb_div_t;
endpackage : ucb_pkg

// ==== verilog/ucb_skid.sv ====
// Two-entry valid/ready buffer on the receive word path
`timescale 1ns/100ps
`default_nettype none
module ucb_skid #(
  parameter int WIDTH = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] spare;
  logic             spare_valid;
  wire              take = in_valid && in_ready;
  wire              give = out_valid && out_ready;

  // Head register drives the output, spare holds a word during a stall
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid   <= 1'b0;
      out_data    <= '0;
      spare       <= '0;
      spare_valid <= 1'b0;
      in_ready    <= 1'b1;
    end
    else
    begin
      if (!out_valid || give)
      begin
        out_valid   <= spare_valid || take;
        out_data    <= spare_valid ? spare : in_data;
        spare_valid <= spare_valid && take;
        if (spare_valid && take)
          spare <= in_data;
        in_ready    <= 1'b1;
      end
      else if (take)
      begin
        spare       <= in_data;
        spare_valid <= 1'b1;
        in_ready    <= 1'b0;
      end
    end
  end

  a_skid_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");
endmodule : ucb_skid
`default_nettype wire

// ==== verilog/ucb_top.sv ====
// UTOPIA receive overrun guard and transmit queue partition control
`timescale 1ns/100ps
`default_nettype none
module ucb_top
  import ucb_pkg::*;
#(
  parameter int WORD_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  input  wire logic              rx_clav,
  output var  logic              rx_enb_n,
  input  wire logic              rx_word_valid,
  input  wire logic [WORD_W-1:0] rx_word_data,
  output var  logic              rx_word_ready,
  input  wire logic              rx_cell_stored,
  output var  logic              proc_valid,
  output var  logic [WORD_W-1:0] proc_data,
  input  wire logic              proc_ready,
  input  wire logic              proc_cell_read,
  output var  logic [6:0]        tx_queue_count,
  output var  logic [7:0]        tx_queue_depth,
  output var  logic [2:0]        tx_queues_per_port,
  output var  logic [5:0]        tx_ports_served
);
  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic [15:0] main_config_buffer_fields;
  logic [15:0] mode_reg;
  logic [4:0]  port_query;
  logic [7:0]  dp_addr;
  logic        dp_write;
  logic        dp_pend;
  logic [31:0] next_rdata;

  wire accept   = hsel && htrans[1] && hready;
  wire wr_main  = dp_pend && dp_write && (dp_addr == UCB_OFS_MAIN);
  wire wr_mode  = dp_pend && dp_write && (dp_addr == UCB_OFS_MODE);
  wire wr_port  = dp_pend && dp_write && (dp_addr == UCB_OFS_PORT);

  // Address phase captured, data phase takes one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_addr   <= 8'h00;
      dp_write  <= 1'b0;
      dp_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end
    else if (dp_pend)
    begin
      dp_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= dp_write ? 32'h0000_0000 : next_rdata;
    end
    else if (accept)
    begin
      dp_addr   <= {haddr[7:2], 2'b00};
      dp_write  <= hwrite;
      dp_pend   <= 1'b1;
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Writable fields; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_config_buffer_fields <= UCB_MAIN_RST;
      mode_reg                  <= UCB_MODE_RST;
      port_query                <= 5'h00;
    end
    else
    begin
      if (wr_main)
        main_config_buffer_fields <= hwdata[15:0] & UCB_MAIN_MASK;
      if (wr_mode)
        mode_reg <= hwdata[15:0] & UCB_MODE_MASK;
      if (wr_port)
        port_query <= hwdata[4:0];
    end
  end

  wire       full_feature_select = main_config_buffer_fields[UCB_BIT_FFS];
  wire       overrun_guard       = main_config_buffer_fields[UCB_BIT_GUARD];
  wire [2:0] div_code            = main_config_buffer_fields[UCB_DIVQ_LO +: 3];
  wire       rx_atm_mode         = mode_reg[UCB_BIT_ATM];
  wire       utopia_level2       = mode_reg[UCB_BIT_LVL2];
  wire [5:0] ports_req           = mode_reg[UCB_PORTS_LO +: 6];

  // ****************************************************************
  // Receive FIFO overrun guard
  // ****************************************************************
  logic       clav_meta;
  logic       clav_sync;
  logic [3:0] cell_count;
  logic [3:0] next_cell_count;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clav_meta <= 1'b0;
      clav_sync <= 1'b0;
    end
    else
    begin
      clav_meta <= rx_clav;
      clav_sync <= clav_meta;
    end
  end

  // Unprocessed cells: stored minus read, saturating at both ends
  always_comb
  begin
    next_cell_count = cell_count;
    if (rx_cell_stored && !proc_cell_read && cell_count != 4'hF)
      next_cell_count = cell_count + 4'h1;
    else if (!rx_cell_stored && proc_cell_read && cell_count != 4'h0)
      next_cell_count = cell_count - 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cell_count <= 4'h0;
    else
      cell_count <= next_cell_count;
  end

  wire fifo_full   = (cell_count >= UCB_FULL_CELLS);
  wire guard_block = overrun_guard && rx_atm_mode && fifo_full;

  // Enable withheld regardless of the PHY's cell-available answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_enb_n <= 1'b0;
    else
      rx_enb_n <= guard_block;
  end

  ucb_skid #(
    .WIDTH (WORD_W)
  ) u_skid (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (rx_word_valid),
    .in_data   (rx_word_data),
    .in_ready  (rx_word_ready),
    .out_valid (proc_valid),
    .out_data  (proc_data),
    .out_ready (proc_ready)
  );

  // ****************************************************************
  // Transmit queue partition
  // ****************************************************************
  logic [6:0] queues;
  logic [7:0] depth;

  always_comb
  begin
    unique case (ucb_div_t'(div_code))
      UCB_DIV_4:  begin queues = 7'd4;  depth = 8'd32;  end
      UCB_DIV_8:  begin queues = 7'd8;  depth = 8'd16;  end
      UCB_DIV_16: begin queues = 7'd16; depth = 8'd8;   end
      UCB_DIV_32: begin queues = 7'd32; depth = 8'd4;   end
      UCB_DIV_64: begin queues = 7'd64; depth = 8'd2;   end
      UCB_DIV_1:  begin queues = 7'd1;  depth = UCB_TX_CELLS; end
      default:    begin queues = 7'd4;  depth = 8'd32;  end
    endcase
  end

  // Light mode with code 100 keeps 64 slots but uses 32 of them
  wire       light_64   = !full_feature_select && (div_code == UCB_DIV_64);
  wire [6:0] queues_use = light_64 ? UCB_Q_LIGHT_64 : queues;
  wire [5:0] port_limit = full_feature_select ? UCB_PORTS_FULL
                                              : UCB_PORTS_LIGHT;
  wire [5:0] ports_zero = (ports_req == 6'h00) ? 6'h01 : ports_req;
  wire [5:0] ports_eff  = (ports_zero > port_limit) ? port_limit : ports_zero;
  wire       multi_phy  = rx_atm_mode && utopia_level2;
  wire [2:0] qpp        = !multi_phy ? 3'h1 :
                          (ports_eff == UCB_PORTS_FULL) ? UCB_QPP_NARROW
                                                        : UCB_QPP_WIDE;
  wire [6:0] port_cap   = (qpp == UCB_QPP_NARROW) ? {1'b0, queues_use[6:1]}
                        : (qpp == UCB_QPP_WIDE)   ? {2'b00, queues_use[6:2]}
                                                  : queues_use;
  wire [6:0] ports_can  = (port_cap == 7'h00) ? 7'h01 : port_cap;
  wire [5:0] served     = !multi_phy ? 6'h01 :
                          (ports_can < {1'b0, ports_eff}) ? ports_can[5:0]
                                                          : ports_eff;
  // Advice flag: more than one queue outside level 2 multi-PHY
  wire       advise_one = !multi_phy && (queues_use != 7'h01);
  wire       light_alt  = !full_feature_select &&
                          (div_code == UCB_DIV_64 || div_code == UCB_DIV_1);
  wire [7:0] qbase      = (qpp == UCB_QPP_NARROW) ? {2'b00, port_query, 1'b0}
                        : (qpp == UCB_QPP_WIDE)   ? {1'b0, port_query, 2'b00}
                                                  : 8'h00;
  wire       port_ok    = ({1'b0, port_query} < served);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_queue_count     <= 7'd4;
      tx_queue_depth     <= 8'd32;
      tx_queues_per_port <= 3'h1;
      tx_ports_served    <= 6'h01;
    end
    else
    begin
      tx_queue_count     <= queues_use;
      tx_queue_depth     <= depth;
      tx_queues_per_port <= qpp;
      tx_ports_served    <= served;
    end
  end

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  wire [31:0] status_word = {8'h00, 8'h00, 2'b00, advise_one,
                             light_alt, clav_sync, guard_block, fifo_full,
                             1'b0, 4'h0, cell_count};
  wire [31:0] qmap_word   = {1'b0, queues_use, depth, 2'b00, served, 5'h00, qpp};
  wire [31:0] port_word   = {15'h0000, port_ok, qbase, 3'b000, port_query};

  always_comb
  begin
    unique case (dp_addr)
      UCB_OFS_MAIN:   next_rdata = {16'h0000, main_config_buffer_fields};
      UCB_OFS_MODE:   next_rdata = {16'h0000, mode_reg};
      UCB_OFS_STATUS: next_rdata = status_word;
      UCB_OFS_QMAP:   next_rdata = qmap_word;
      UCB_OFS_PORT:   next_rdata = port_word;
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_full_guarded;
    overrun_guard && rx_atm_mode && fifo_full;
  endsequence

  sequence s_multi_wide;
    multi_phy && ports_eff != UCB_PORTS_FULL;
  endsequence

  a_enb_release: assert property (@(posedge hclk) disable iff (!hresetn)
    !guard_block |=> !rx_enb_n)
    else $error("receive enable withdrawn without a full guarded FIFO");

  a_wide_qpp: assert property (@(posedge hclk) disable iff (!hresetn)
    s_multi_wide |=> tx_queues_per_port == UCB_QPP_WIDE)
    else $error("fewer than 32 ports must use four queues each");

  a_one_port: assert property (@(posedge hclk) disable iff (!hresetn)
    !multi_phy |=> tx_ports_served == 6'h01 && tx_queues_per_port == 3'h1)
    else $error("single port operation must serve one port");

  a_served_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    multi_phy |-> served <= ports_eff && {1'b0, served} <= ports_can)
    else $error("more ports served than queues allow");

  a_guard_block: assert property (@(posedge hclk) disable iff (!hresetn)
    s_full_guarded |=> rx_enb_n)
    else $error("receive enable not withdrawn when full");

  a_full_thresh: assert property (@(posedge hclk) disable iff (!hresetn)
    fifo_full == (cell_count > 4'h3))
    else $error("full threshold is not four cells");

  a_phy_mode_free: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_atm_mode |=> !rx_enb_n)
    else $error("guard acted outside ATM mode");

  a_guard_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !overrun_guard |=> !rx_enb_n)
    else $error("receive enable dropped with guard cleared");

  a_part_cells: assert property (@(posedge hclk) disable iff (!hresetn)
    !light_64 |-> ({1'b0, queues} * {1'b0, depth}) == 16'd128)
    else $error("partition does not cover 128 cells");

  a_code_011: assert property (@(posedge hclk) disable iff (!hresetn)
    div_code == 3'h3 |=> tx_queue_count == 7'd32 && tx_queue_depth == 8'd4)
    else $error("code 011 not 32 queues of 4");

  a_port_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    !full_feature_select |=> tx_ports_served <= 6'd16)
    else $error("light mode serves more than 16 ports");

  a_narrow_qpp: assert property (@(posedge hclk) disable iff (!hresetn)
    multi_phy && ports_eff == 6'd32 |=> tx_queues_per_port == 3'h2)
    else $error("32 ports must use two queues each");

  a_four_serve: assert property (@(posedge hclk) disable iff (!hresetn)
    multi_phy && ports_eff == 6'd32 && div_code == 3'h0 ##1 $stable(div_code)
    |-> tx_ports_served == 6'd2)
    else $error("four queues must serve two ports");

  a_light_64: assert property (@(posedge hclk) disable iff (!hresetn)
    light_64 |=> tx_queue_count == 7'd32)
    else $error("light code 100 must use 32 queues");

  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !dp_pend |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not one wait state");
endmodule : ucb_top
`default_nettype wire

// ==== bench/ucb_phy_model.sv ====
// Behavioural PHY-side source: receive words, cell-stored pulses, cell available
`timescale 1ns/100ps
`default_nettype none
module ucb_phy_model (
  input  wire logic       hclk,
  input  wire logic       rx_word_ready,
  output var  logic       rx_clav,
  output var  logic       rx_word_valid,
  output var  logic [7:0] rx_word_data,
  output var  logic       rx_cell_stored
);
  initial
  begin
    rx_clav        = 1'b1;
    rx_word_valid  = 1'b0;
    rx_word_data   = 8'hFF;
    rx_cell_stored = 1'b0;
  end
  // ****************************************************************
  // Word held until taken; idle data is the inverse of the last word
  // ****************************************************************
  task automatic send_word(input logic [7:0] d, input int slow, output logic ok);
    int n;
    begin
      n = 0;
      repeat (slow) @(posedge hclk);
      rx_word_valid <= 1'b1;
      rx_word_data  <= d;
      do
      begin
        @(posedge hclk);
        n++;
      end while (rx_word_ready !== 1'b1 && n < 50);
      rx_word_valid <= 1'b0;
      rx_word_data  <= ~d;
      ok = (n < 50);
      @(posedge hclk);
    end
  endtask : send_word
  // Back-to-back cell pulses, one per cycle
  task automatic cells(input int n);
    begin
      rx_cell_stored <= 1'b1;
      repeat (n) @(posedge hclk);
      rx_cell_stored <= 1'b0;
    end
  endtask : cells
endmodule : ucb_phy_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the cell buffer configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ucb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ok;
  logic [7:0]  haddr, proc_data, rx_word_data, tx_queue_depth;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tx_queues_per_port;
  logic [31:0] hwdata, hrdata, rd;
  logic        rx_clav, rx_enb_n, rx_word_valid, rx_word_ready, rx_cell_stored;
  logic        proc_valid, proc_ready, proc_cell_read;
  logic [6:0]  tx_queue_count;
  logic [5:0]  tx_ports_served;
  int          n_errors, samples_checked, k, n;
  assign hready = hreadyout;
  ucb_top #(.WORD_W(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_clav(rx_clav),
    .rx_enb_n(rx_enb_n), .rx_word_valid(rx_word_valid), .rx_word_data(rx_word_data),
    .rx_word_ready(rx_word_ready), .rx_cell_stored(rx_cell_stored), .proc_valid(proc_valid),
    .proc_data(proc_data), .proc_ready(proc_ready), .proc_cell_read(proc_cell_read),
    .tx_queue_count(tx_queue_count), .tx_queue_depth(tx_queue_depth),
    .tx_queues_per_port(tx_queues_per_port), .tx_ports_served(tx_ports_served));
  ucb_phy_model phy (.hclk(hclk), .rx_word_ready(rx_word_ready), .rx_clav(rx_clav),
    .rx_word_valid(rx_word_valid), .rx_word_data(rx_word_data),
    .rx_cell_stored(rx_cell_stored));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic give_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask : give_verdict
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    begin
      samples_checked++;
      if (g !== e)
      begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    begin
      chk_reg(g, e);
    end
  endtask : chk_pin
  // ****************************************************************
  // AHB-Lite single word transfer
  // ****************************************************************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int t;
    begin
      t = 0;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do
      begin
        @(posedge hclk);
        t++;
      end while (hreadyout !== 1'b1 && t < 50);
      if (hreadyout !== 1'b1)
      begin
        n_errors++;
        give_verdict();
      end
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do
      begin
        @(posedge hclk);
        t++;
      end while (hreadyout !== 1'b1 && t < 100);
      rd = hrdata;
      if (hreadyout !== 1'b1)
      begin
        n_errors++;
        give_verdict();
      end
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      bus(a, 1'b1, d);
      repeat (3) @(posedge hclk);
    end
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      bus(a, 1'b0, 32'h0000_0000);
      chk_reg(rd & m, e);
    end
  endtask : rd_chk
  task automatic reads(input int c);
    begin
      proc_cell_read <= 1'b1;
      repeat (c) @(posedge hclk);
      proc_cell_read <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : reads
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  logic [6:0]  q_cnt [6] = '{7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h01};
  logic [7:0]  q_dep [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h80};
  logic [15:0] m_cfg [6] = '{16'h0010, 16'h0110, 16'h0210, 16'h0200, 16'h0400, 16'h0410};
  logic [15:0] d_cfg [6] = '{16'h2003, 16'h2003, 16'h1003, 16'h2003, 16'h1003, 16'h2003};
  logic [2:0]  w_qpp [6] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h2};
  logic [5:0]  w_srv [6] = '{6'h02, 6'h04, 6'h04, 6'h04, 6'h08, 6'h20};
  logic [7:0]  want [3]  = '{8'hA5, 8'h5A, 8'hC3};
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    proc_ready = 1'b1;
    proc_cell_read = 1'b0;
    repeat (12) @(posedge hclk);
    chk_pin(tx_queue_count, 32'h4);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(UCB_OFS_MAIN, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_pin(hresp, 32'h0);
    rd_chk(UCB_OFS_MODE, 32'hFFFF_FFFF, 32'h0000_0101);
    wr(UCB_OFS_MAIN, 32'hFFFF_FFFF);
    rd_chk(UCB_OFS_MAIN, 32'hFFFF_FFFF, 32'h0000_0750);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    for (k = 0; k < 6; k++)
    begin
      wr(UCB_OFS_MAIN, 32'h0010 | (k << 8));
      chk_pin(tx_queue_count, q_cnt[k]);
      chk_pin(tx_queue_depth, q_dep[k]);
      rd_chk(UCB_OFS_STATUS, 32'h2000, (k == 5) ? 32'h0 : 32'h2000);
    end
    wr(UCB_OFS_MAIN, 32'h0000_0500);
    rd_chk(UCB_OFS_STATUS, 32'h1000, 32'h1000);
    for (k = 0; k < 6; k++)
    begin
      wr(UCB_OFS_MAIN, m_cfg[k]);
      wr(UCB_OFS_MODE, d_cfg[k]);
      chk_pin(tx_queues_per_port, w_qpp[k]);
      chk_pin(tx_ports_served, w_srv[k]);
    end
    rd_chk(UCB_OFS_QMAP, 32'h7F00_0000, 32'h4000_0000);
    wr(UCB_OFS_PORT, 32'h0000_0005);
    rd_chk(UCB_OFS_PORT, 32'h0001_FFFF, 32'h0001_0A05);
    wr(UCB_OFS_MAIN, 32'h0000_0400);
    wr(UCB_OFS_MODE, 32'h0000_1003);
    rd_chk(UCB_OFS_QMAP, 32'h7F00_0000, 32'h2000_0000);
    wr(UCB_OFS_PORT, 32'h0000_0009);
    rd_chk(UCB_OFS_PORT, 32'h0001_FFFF, 32'h0000_2409);
    // Receive overrun guard
    wr(UCB_OFS_MAIN, 32'h0000_0040);
    wr(UCB_OFS_MODE, 32'h0000_0101);
    phy.cells(3);
    repeat (3) @(posedge hclk);
    chk_pin(rx_enb_n, 32'h0);
    phy.cells(1);
    repeat (3) @(posedge hclk);
    chk_pin(rx_enb_n, 32'h1);
    rd_chk(UCB_OFS_STATUS, 32'h0E0F, 32'h0E04);
    reads(1);
    chk_pin(rx_enb_n, 32'h0);
    phy.cells(1);
    repeat (3) @(posedge hclk);
    chk_pin(rx_enb_n, 32'h1);
    wr(UCB_OFS_MODE, 32'h0000_0100);
    chk_pin(rx_enb_n, 32'h0);
    wr(UCB_OFS_MODE, 32'h0000_0101);
    wr(UCB_OFS_MAIN, 32'h0000_0000);
    chk_pin(rx_enb_n, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(UCB_OFS_STATUS, 32'h000F, 32'h0000);
    // Word buffer fill under stall, then drain in order
    proc_ready <= 1'b0;
    fork
      begin
        phy.send_word(want[0], 0, ok);
        chk_pin(ok, 32'h1);
        phy.send_word(want[1], 0, ok);
        chk_pin(ok, 32'h1);
        phy.send_word(want[2], 2, ok);
        chk_pin(ok, 32'h1);
      end
      begin
        repeat (6) @(posedge hclk);
        chk_pin(rx_word_ready, 32'h0);
        chk_pin(proc_data, want[0]);
        proc_ready <= 1'b1;
        k = 0;
        n = 0;
        while (k < 3 && n < 50)
        begin
          @(posedge hclk);
          n++;
          if (proc_valid === 1'b1)
          begin
            chk_pin(proc_data, want[k]);
            k++;
          end
        end
        chk_pin(k, 32'h3);
      end
    join
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
